// ===== logic/pfm_pin_mux.sv
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module pfm_pin_mux import pfm_pkg::*; (
  // Clock and reset
  input  wire logic                               i_core_clk,
  input  wire logic                               i_reset,

  // Register port
  input  wire logic [ADDR_W-1:0]                  i_addr,
  input  wire logic [DATA_W-1:0]                  i_wr_data,
  input  wire logic                               i_wr_en,
  input  wire logic                               i_rd_en,
  output logic      [DATA_W-1:0]                  o_rd_data,

  // Package pins
  input  wire logic [NUM_PINS-1:0]                i_pin_in,
  output logic      [NUM_PINS-1:0]                o_pin_out,
  output logic      [NUM_PINS-1:0]                o_pin_oe,
  input  wire logic                               i_debug_port_reset_n,

  // Emulated power well states
  input  wire logic                               i_well_a_on,
  input  wire logic                               i_well_b_on,

  // Peripheral side
  input  wire logic [NUM_PINS-1:0][FN_SLOTS-1:0]  i_alt_out,
  input  wire logic [NUM_PINS-1:0][FN_SLOTS-1:0]  i_alt_oe,
  output logic      [NUM_PINS-1:0][FN_SLOTS-1:0]  o_alt_in,

  // Debug port side
  input  wire logic [NUM_PINS-1:0]                i_dbg_out,
  input  wire logic [NUM_PINS-1:0]                i_dbg_oe,
  output logic      [NUM_PINS-1:0]                o_dbg_in,
  output logic                                    o_dbg_route
);

  // Registers
  logic [NUM_PINS-1:0][DATA_W-1:0]   ctrl;
  logic [DBG_EN_W-1:0]               dbg_en;
  logic [NUM_PINS-1:0]               cfg_err;
  logic                              dup_err;
  logic [NUM_PINS-1:0]               gpio_state;

  // Synchronised inputs
  logic [NUM_PINS-1:0]               pin_sync;
  logic                              dbg_rst_n_sync;

  // Combinational
  logic                              dbg_route;
  logic [NUM_PINS-1:0]               next_pin_out;
  logic [NUM_PINS-1:0]               next_pin_oe;
  logic [NUM_PINS-1:0][FN_SLOTS-1:0] next_alt_in;
  logic [NUM_PINS-1:0]               next_dbg_in;
  logic [NUM_PINS-1:0]               next_gpio_in;
  logic [NUM_PINS-1:0]               pgs_viol;
  logic                              dup_both;
  logic                              wr_ctrl;
  logic [NUM_PINS-1:0]               cfg_clr;
  logic                              dup_clr;
  logic [DATA_W-1:0]                 next_rd_data;

  // Pins and the debug reset come from outside the clock domain
  pfm_sync2 #(
    .WIDTH   (NUM_PINS + 1),
    .RST_VAL ({(NUM_PINS + 1){1'h0}})
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_async    ({i_debug_port_reset_n, i_pin_in}),
    .o_sync     ({dbg_rst_n_sync, pin_sync})
  );

  // Debug routing needs the released reset and a nonzero enable field.
  // The control words carry no code for it.
  always_comb begin
    dbg_route = dbg_rst_n_sync && (dbg_en != DBG_EN_W'(0));
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      pfm_pin_slice #(
        .KIND   (SLOT_KIND[g]),
        .GATE   (GATE_VAL[g]),
        .ONLY00 (PGS00_ONLY[g]),
        .UNGATE (UNGATED[g]),
        .OVP    (OVP_PINS[g])
      ) u_slice (
        .i_pin_in       (pin_sync[g]),
        .i_fn           (ctrl[g][CTRL_FN_LSB +: FN_W]),
        .i_pgs          (ctrl[g][CTRL_PGS_LSB +: 2]),
        .i_gpio_out     (ctrl[g][CTRL_OUT_BIT]),
        .i_gpio_oe      (ctrl[g][CTRL_OE_BIT]),
        .i_repeat       (ctrl[g][CTRL_RPT_BIT]),
        .i_well_a_on    (i_well_a_on),
        .i_well_b_on    (i_well_b_on),
        .i_dbg_route    (dbg_route && DBG_PINS[g]),
        .i_dbg_out      (i_dbg_out[g]),
        .i_dbg_oe       (i_dbg_oe[g]),
        .i_alt_out      (i_alt_out[g]),
        .i_alt_oe       (i_alt_oe[g]),
        .o_next_pin_out (next_pin_out[g]),
        .o_next_pin_oe  (next_pin_oe[g]),
        .o_next_slot_in (next_alt_in[g]),
        .o_next_dbg_in  (next_dbg_in[g]),
        .o_next_gpio_in (next_gpio_in[g])
      );
    end
  endgenerate

  // Misconfiguration monitors
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      pgs_viol[p] = PGS00_ONLY[p][ctrl[p][CTRL_FN_LSB +: FN_W]]
                    && (ctrl[p][CTRL_PGS_LSB +: 2] != PGS_ALWAYS);
    end
    dup_both = (ctrl[DUP_PRI_PIN][CTRL_FN_LSB +: FN_W] == DUP_PRI_FN)
               && (ctrl[DUP_ALT_PIN][CTRL_FN_LSB +: FN_W] == DUP_ALT_FN);
  end

  // Write decode
  always_comb begin
    wr_ctrl = i_wr_en && (i_addr < ADDR_W'(NUM_PINS));
    cfg_clr = '0;
    dup_clr = 1'h0;
    if (i_wr_en && (i_addr == ADDR_CFG_ERR)) begin
      cfg_clr = i_wr_data[NUM_PINS-1:0];
      dup_clr = i_wr_data[DUP_ERR_BIT];
    end
  end

  // Pin control words
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        ctrl[p] <= DATA_W'(DEFAULT_FN[p]) << CTRL_FN_LSB;
      end
    end else if (wr_ctrl) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        if (i_addr[PIN_IDX_W-1:0] == PIN_IDX_W'(p)) begin
          // Repeater bit is not stored on protected pins
          ctrl[p] <= i_wr_data & (OVP_PINS[p] ? CTRL_MASK_OVP : CTRL_MASK);
        end
      end
    end
  end

  // Debug enable field
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      dbg_en <= '0;
    end else if (i_wr_en && (i_addr == ADDR_DBG_EN)) begin
      dbg_en <= i_wr_data[DBG_EN_W-1:0];
    end
  end

  // Sticky error flags, write one to clear; a new event beats the clear
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cfg_err <= '0;
      dup_err <= 1'h0;
    end else begin
      cfg_err <= (cfg_err & ~cfg_clr) | pgs_viol;
      dup_err <= (dup_err && !dup_clr) || dup_both;
    end
  end

  // Registered pin and peripheral side
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_pin_out   <= '0;
      o_pin_oe    <= '0;
      o_alt_in    <= GATE_VAL;
      o_dbg_in    <= '0;
      o_dbg_route <= 1'h0;
      gpio_state  <= '0;
    end else begin
      o_pin_out   <= next_pin_out;
      o_pin_oe    <= next_pin_oe;
      o_alt_in    <= next_alt_in;
      o_dbg_in    <= next_dbg_in;
      o_dbg_route <= dbg_route;
      gpio_state  <= next_gpio_in;
    end
  end

  // Read mux; data valid only in the cycle after the strobe
  always_comb begin
    next_rd_data = '0;
    if (i_addr < ADDR_W'(NUM_PINS)) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        if (i_addr[PIN_IDX_W-1:0] == PIN_IDX_W'(p)) begin
          next_rd_data = ctrl[p];
        end
      end
    end else begin
      unique case (i_addr)
        ADDR_DBG_EN: begin
          next_rd_data = DATA_W'(dbg_en);
        end
        ADDR_PIN_STATE: begin
          next_rd_data = DATA_W'(gpio_state);
        end
        ADDR_CFG_ERR: begin
          next_rd_data = DATA_W'(cfg_err);
          next_rd_data[DUP_ERR_BIT] = dup_err;
        end
        ADDR_ROUTE: begin
          next_rd_data = {13'h0000, i_well_b_on, i_well_a_on, dbg_route};
        end
        default: begin
          next_rd_data = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rd_data <= '0;
    end else if (i_rd_en) begin
      o_rd_data <= next_rd_data;
    end else begin
      o_rd_data <= '0;
    end
  end

endmodule

// ===== logic/pfm_pkg.sv
// Summary of operation
// - Each pin's gate-select field controls emulated power well of pin and its signals.
// - Restricted signals work only with gate-select 00; others accept every setting.
// - Unselected or power-gated input slots present their fixed gated value, except ungated slots, which follow the pin.
// - Ungated signals follow the pin even while the emulated well is off.
// - Gated values are per signal: two-wire and power-good high, others low.
// - Gated value of an output slot never decides what the pin drives.
// - Over-voltage protected pins offer no repeater mode.
// - Debug reset released: debug signals own shared pins, control registers ignored.
// - Debug reset asserted: debug signals cut off, control registers select function.
// - No control register encoding can route the debug port to pins.
// - Debug routing also needs any of debug enable bits 2 to 0 set.
// - Each pin resets to its first listed function, usually GPIO at 0.
// - Gate-select 11 disables the pin's input path.
package pfm_pkg;
  localparam int NUM_PINS  = 8;
  localparam int FN_SLOTS  = 4;
  localparam int FN_W      = 2;
  localparam int PIN_IDX_W = 3;
  localparam int ADDR_W    = 5;
  localparam int DATA_W    = 16;
  localparam int DBG_EN_W  = 3;

  // Control register fields
  localparam int CTRL_OUT_BIT = 0;
  localparam int CTRL_OE_BIT  = 1;
  localparam int CTRL_RPT_BIT = 2;
  localparam int CTRL_PGS_LSB = 4;
  localparam int CTRL_FN_LSB  = 8;
  localparam logic [DATA_W-1:0] CTRL_MASK     = 16'h0337;
  localparam logic [DATA_W-1:0] CTRL_MASK_OVP = 16'h0333;

  // Register addresses; pin control words sit at 0 .. NUM_PINS-1
  localparam logic [ADDR_W-1:0] ADDR_DBG_EN    = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_PIN_STATE = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_CFG_ERR   = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_ROUTE     = 5'h13;
  localparam int DUP_ERR_BIT = 8;

  // Gate-select encodings
  localparam logic [1:0] PGS_ALWAYS = 2'h0;
  localparam logic [1:0] PGS_WELL_A = 2'h1;
  localparam logic [1:0] PGS_WELL_B = 2'h2;
  localparam logic [1:0] PGS_IN_OFF = 2'h3;

  // Slot kinds: bit 0 input capable, bit 1 output capable
  localparam logic [1:0] KIND_NONE  = 2'h0;
  localparam logic [1:0] KIND_IN    = 2'h1;
  localparam logic [1:0] KIND_OUT   = 2'h2;
  localparam logic [1:0] KIND_BIDIR = 2'h3;

  // Per pin tables, pin 7 first, slots fn3..fn0 within a pin
  localparam logic [NUM_PINS-1:0][FN_SLOTS-1:0][1:0] SLOT_KIND = 64'h072F_1F2F_0707_0B07;
  localparam logic [NUM_PINS-1:0][FN_SLOTS-1:0] GATE_VAL   = 32'h0220_0002;
  localparam logic [NUM_PINS-1:0][FN_SLOTS-1:0] PGS00_ONLY = 32'h2000_2022;
  localparam logic [NUM_PINS-1:0][FN_SLOTS-1:0] UNGATED    = 32'h3111_1111;
  localparam logic [NUM_PINS-1:0][FN_W-1:0]     DEFAULT_FN = 16'h4000;
  localparam logic [NUM_PINS-1:0] OVP_PINS = 8'h21;
  localparam logic [NUM_PINS-1:0] DBG_PINS = 8'h60;

  // Signal with a duplicate routing
  localparam int DUP_PRI_PIN = 4;
  localparam logic [FN_W-1:0] DUP_PRI_FN = 2'h2;
  localparam int DUP_ALT_PIN = 6;
  localparam logic [FN_W-1:0] DUP_ALT_FN = 2'h2;
endpackage

// ===== logic/pfm_sync2.sv
`timescale 1ns/1ps
module pfm_sync2 import pfm_pkg::*; #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = {WIDTH{1'h0}}
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  // Levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      meta   <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// ===== logic/pfm_pin_slice.sv
`timescale 1ns/1ps
module pfm_pin_slice import pfm_pkg::*; #(
  parameter logic [FN_SLOTS-1:0][1:0] KIND   = 8'h0B,
  parameter logic [FN_SLOTS-1:0]      GATE   = 4'h0,
  parameter logic [FN_SLOTS-1:0]      ONLY00 = 4'h0,
  parameter logic [FN_SLOTS-1:0]      UNGATE = 4'h1,
  parameter logic                     OVP    = 1'h0
) (
  // Pin and control
  input  wire logic                i_pin_in,
  input  wire logic [FN_W-1:0]     i_fn,
  input  wire logic [1:0]          i_pgs,
  input  wire logic                i_gpio_out,
  input  wire logic                i_gpio_oe,
  input  wire logic                i_repeat,
  input  wire logic                i_well_a_on,
  input  wire logic                i_well_b_on,
  // Debug override
  input  wire logic                i_dbg_route,
  input  wire logic                i_dbg_out,
  input  wire logic                i_dbg_oe,
  // Peripheral slots
  input  wire logic [FN_SLOTS-1:0] i_alt_out,
  input  wire logic [FN_SLOTS-1:0] i_alt_oe,
  // Next values
  output logic                     o_next_pin_out,
  output logic                     o_next_pin_oe,
  output logic      [FN_SLOTS-1:0] o_next_slot_in,
  output logic                     o_next_dbg_in,
  output logic                     o_next_gpio_in
);
  logic                well_on;
  logic                in_en;
  logic [FN_SLOTS-1:0] live;

  always_comb begin
    in_en = (i_pgs != PGS_IN_OFF);
    unique case (i_pgs)
      PGS_WELL_A: well_on = i_well_a_on;
      PGS_WELL_B: well_on = i_well_b_on;
      default:    well_on = 1'h1;
    endcase
    o_next_pin_out = 1'h0;
    o_next_pin_oe  = 1'h0;
    for (int s = 0; s < FN_SLOTS; s++) begin
      // Reserved slots have KIND_NONE and never go live
      live[s] = (i_fn == FN_W'(s)) && (KIND[s] != KIND_NONE) && !i_dbg_route
                && (ONLY00[s] ? (i_pgs == PGS_ALWAYS) : well_on);
      if (UNGATE[s]) begin
        o_next_slot_in[s] = in_en ? i_pin_in : GATE[s];
      end else begin
        o_next_slot_in[s] = (live[s] && in_en && KIND[s][0]) ? i_pin_in : GATE[s];
      end
      // Gated value of an output slot stays internal
      if (s != 0 && live[s] && KIND[s][1]) begin
        o_next_pin_out = i_alt_out[s];
        o_next_pin_oe  = i_alt_oe[s];
      end
    end
    if (i_dbg_route) begin
      o_next_pin_out = i_dbg_out;
      o_next_pin_oe  = i_dbg_oe;
    end else if (i_fn == FN_W'(0)) begin
      o_next_pin_out = (i_repeat && !OVP) ? i_pin_in : i_gpio_out;
      o_next_pin_oe  = i_gpio_oe && well_on;
    end
    o_next_dbg_in  = i_dbg_route ? i_pin_in : 1'h0;
    o_next_gpio_in = in_en && i_pin_in;
  end
endmodule

// ===== bench/pfm_pin_mux_properties.sv
`timescale 1ns/1ps
module pfm_pin_mux_checker import pfm_pkg::*; (
  // Clock and reset
  input wire logic                              i_core_clk,
  input wire logic                              i_reset,
  // Register port
  input wire logic [ADDR_W-1:0]                 i_addr,
  input wire logic                              i_rd_en,
  input wire logic [DATA_W-1:0]                 o_rd_data,
  // Pins and sides
  input wire logic [NUM_PINS-1:0]               o_pin_oe,
  input wire logic                              i_debug_port_reset_n,
  input wire logic [NUM_PINS-1:0][FN_SLOTS-1:0] o_alt_in,
  input wire logic [NUM_PINS-1:0]               i_dbg_oe,
  input wire logic [NUM_PINS-1:0]               o_dbg_in,
  input wire logic                              o_dbg_route
);
  logic [NUM_PINS-1:0][FN_SLOTS-1:0] none_mask;

  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      for (int s = 0; s < FN_SLOTS; s++) begin
        none_mask[p][s] = (SLOT_KIND[p][s] == KIND_NONE);
      end
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  rd_idle_zero_a: assert property (!$past(i_rd_en) |-> o_rd_data == '0)
    else $error("read data not zero outside a read");
  rd_unmapped_a: assert property ($past(i_rd_en) && ($past(i_addr) > ADDR_ROUTE
    || $past(i_addr[4:3]) == 2'h1) |-> o_rd_data == '0)
    else $error("unmapped read returned data");
  reset_state_a: assert property ($fell(i_reset) |-> o_pin_oe == '0
    && o_alt_in == GATE_VAL && !o_dbg_route) else $error("wrong state after reset");
  reserved_gated_a: assert property (((o_alt_in ^ GATE_VAL) & none_mask) == '0)
    else $error("empty slot left its gated value");
  dbg_pins_only_a: assert property ((o_dbg_in & ~DBG_PINS) == '0)
    else $error("debug input seen on a plain pin");
  dbg_rise_a: assert property ($rose(o_dbg_route) |-> $past(i_debug_port_reset_n, 3))
    else $error("debug route rose while debug reset held");
  dbg_cut_a: assert property (!i_debug_port_reset_n [*4] |-> !o_dbg_route
    && o_dbg_in == '0) else $error("debug route active under debug reset");
  dbg_drive_a: assert property (o_dbg_route && $past(o_dbg_route) && $past(o_dbg_route, 2)
    |-> (o_pin_oe & DBG_PINS) == ($past(i_dbg_oe) & DBG_PINS))
    else $error("debug pins not driven by debug port");
endmodule

// ===== bench/pfm_pad_model.sv
`timescale 1ns/1ps
module pfm_pad_model import pfm_pkg::*; #(
  parameter logic [NUM_PINS-1:0] PULL_LEVEL = 8'h00
) (
  // Design drive
  input  wire logic [NUM_PINS-1:0] i_pin_out,
  input  wire logic [NUM_PINS-1:0] i_pin_oe,
  // Board drive
  input  wire logic [NUM_PINS-1:0] i_ext_level,
  input  wire logic [NUM_PINS-1:0] i_ext_drive,
  // Resolved pad level
  output logic      [NUM_PINS-1:0] o_pin_level
);
  // Released pads fall to their resistor, never keep the last level
  assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_drive & i_ext_level)
    | (~i_pin_oe & ~i_ext_drive & PULL_LEVEL);
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top import pfm_pkg::*;;
  logic                              core_clk = 1'h0;
  logic                              reset = 1'h1;
  logic [ADDR_W-1:0]                 addr = 5'h00;
  logic [DATA_W-1:0]                 wr_data = 16'h0000;
  logic                              wr_en = 1'h0;
  logic                              rd_en = 1'h0;
  logic [DATA_W-1:0]                 rd_data;
  logic [NUM_PINS-1:0]               pin_level;
  logic [NUM_PINS-1:0]               pin_out;
  logic [NUM_PINS-1:0]               pin_oe;
  logic [NUM_PINS-1:0]               ext_level = 8'h00;
  logic                              dbg_rst_n = 1'h0;
  logic                              well_a = 1'h1;
  logic                              well_b = 1'h1;
  logic [NUM_PINS-1:0][FN_SLOTS-1:0] alt_out = 32'hFFFFFFFF;
  logic [NUM_PINS-1:0][FN_SLOTS-1:0] alt_oe = 32'hFFFFFFFF;
  logic [NUM_PINS-1:0][FN_SLOTS-1:0] alt_in;
  logic [NUM_PINS-1:0]               dbg_out = 8'h60;
  logic [NUM_PINS-1:0]               dbg_oe = 8'h40;
  logic [NUM_PINS-1:0]               dbg_in;
  logic                              dbg_route;
  int                                miscompares = 0;
  int                                check_count = 0;

  always #4 core_clk = ~core_clk;

  pfm_pin_mux dut_u (.i_core_clk(core_clk), .i_reset(reset), .i_addr(addr),
    .i_wr_data(wr_data), .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data),
    .i_pin_in(pin_level), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .i_debug_port_reset_n(dbg_rst_n), .i_well_a_on(well_a), .i_well_b_on(well_b),
    .i_alt_out(alt_out), .i_alt_oe(alt_oe), .o_alt_in(alt_in), .i_dbg_out(dbg_out),
    .i_dbg_oe(dbg_oe), .o_dbg_in(dbg_in), .o_dbg_route(dbg_route));

  // Pins 2 to 5 are driven by the board, the rest only pulled
  pfm_pad_model pad_u (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_level(ext_level),
    .i_ext_drive(8'h3C), .o_pin_level(pin_level));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle;
    repeat (5) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'h1;
    @(posedge core_clk);
    wr_en <= 1'h0;
  endtask

  task automatic wr_settle(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wr(a, d);
    settle;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge core_clk);
    rd_en <= 1'h0;
    #1;
    chk("read data", 32'(exp), 32'(rd_data));
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'h0;
    settle;
    chk("alt in", 32'(GATE_VAL), 32'(alt_in));
    chk("pin oe", 32'h0, 32'(pin_oe));
    rd(5'h07, 16'h0100);
    rd(5'h00, 16'h0000);
    rd(5'h0A, 16'h0000);
    $display("test reset done");
    ext_level <= 8'h04;
    wr_settle(5'h02, 16'h0100);
    chk("pin2 in", 32'h3, 32'(alt_in[2]));
    chk("pin0 in", 32'h2, 32'(alt_in[0]));
    wr_settle(5'h02, 16'h0000);
    chk("pin2 in", 32'h1, 32'(alt_in[2]));
    wr_settle(5'h02, 16'h0300);
    chk("pin2 in", 32'h1, 32'(alt_in[2]));
    chk("pin2 oe", 32'h0, 32'(pin_oe[2]));
    $display("test select done");
    for (int k = 1; k < 3; k++) begin
      wr(5'h02, (k == 1) ? 16'h0110 : 16'h0120);
      well_a <= (k != 1);
      well_b <= (k != 2);
      settle;
      chk("well off", 32'h1, 32'(alt_in[2]));
      well_a <= 1'h1;
      well_b <= 1'h1;
      settle;
      chk("well on", 32'h3, 32'(alt_in[2]));
    end
    rd(ADDR_PIN_STATE, 16'h0004);
    wr_settle(5'h02, 16'h0130);
    chk("input off", 32'h0, 32'(alt_in[2]));
    rd(ADDR_PIN_STATE, 16'h0000);
    wr(5'h02, 16'h0000);
    $display("test wells done");
    ext_level <= 8'h0C;
    wr_settle(5'h03, 16'h0110);
    chk("pin3 in", 32'h1, 32'(alt_in[3]));
    rd(ADDR_CFG_ERR, 16'h0008);
    wr_settle(5'h03, 16'h0100);
    chk("pin3 in", 32'h3, 32'(alt_in[3]));
    wr(ADDR_CFG_ERR, 16'h0008);
    rd(ADDR_CFG_ERR, 16'h0000);
    $display("test restricted done");
    wr_settle(5'h01, 16'h0100);
    chk("pin1 drive", 32'h3, 32'({pin_oe[1], pin_out[1]}));
    chk("pin1 in", 32'h1, 32'(alt_in[1]));
    wr(5'h00, 16'h0004);
    rd(5'h00, 16'h0000);
    wr(5'h03, 16'h0004);
    rd(5'h03, 16'h0004);
    $display("test output done");
    ext_level <= 8'h20;
    dbg_rst_n <= 1'h1;
    wr_settle(5'h05, 16'h0100);
    chk("route", 32'h0, 32'(dbg_route));
    chk("debug oe", 32'h1, 32'(pin_oe[6:5]));
    for (int e = 1; e < 8; e++) begin
      wr_settle(ADDR_DBG_EN, 16'(e));
      chk("route", 32'h1, 32'(dbg_route));
    end
    chk("debug oe", 32'h2, 32'(pin_oe[6:5]));
    chk("debug in", 32'h60, 32'(dbg_in));
    dbg_rst_n <= 1'h0;
    settle;
    chk("route", 32'h0, 32'(dbg_route));
    chk("debug in", 32'h0, 32'(dbg_in));
    chk("debug oe", 32'h1, 32'(pin_oe[6:5]));
    $display("test debug done");
    // Only the primary routing is selected; the alternate stays off
    wr_settle(5'h04, 16'h0200);
    rd(ADDR_CFG_ERR, 16'h0000);
    $display("test routing done");
    test_done;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    test_done;
  end
endmodule

bind pfm_pin_mux pfm_pin_mux_checker chk_u (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_addr(i_addr), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_pin_oe(o_pin_oe),
  .i_debug_port_reset_n(i_debug_port_reset_n), .o_alt_in(o_alt_in), .i_dbg_oe(i_dbg_oe),
  .o_dbg_in(o_dbg_in), .o_dbg_route(o_dbg_route));
